// *** src/hil_pkg.sv ***
// package for the hardware interrupt and log pointer block
package hil_pkg;
   localparam logic [7:0] HIL_OFS_HW_PEND = 8'h06;
   localparam logic [7:0] HIL_OFS_TERM_PEND = 8'h09;
   localparam logic [7:0] HIL_OFS_COUNT_LOG = 8'h0A;
   localparam logic [7:0] HIL_OFS_HW_EN = 8'h0F;
   localparam logic [7:0] HIL_OFS_HW_OE = 8'h13;
   localparam int HIL_SUMMARY_BIT = 2;
   localparam logic [15:0] HIL_HW_EVENT_MASK = 16'hFFF8;
   localparam logic [15:0] HIL_HW_EN_RESET = 16'h7800;
   localparam logic [15:0] HIL_HW_OE_RESET = 16'h0000;
   localparam int HIL_COUNT_LSB = 9;
   localparam logic [6:0] HIL_COUNT_MAX = 7'h7F;
   localparam logic [8:0] HIL_LOG_START = 9'h180;
   localparam logic [8:0] HIL_LOG_LAST_PAIR = 9'h1BE;
   localparam logic [15:0] HIL_LOG_ADDR_WORD = 16'h0000;
   // register access from the serial host port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } hil_req_t;
   // one log memory write
   typedef struct packed {
      logic we;
      logic [8:0] addr;
      logic [15:0] data;
   } hil_log_wr_t;
   typedef enum logic [1:0] {
      HIL_IDLE = 2'b00,
      HIL_WR_ID = 2'b01,
      HIL_WR_ADDR = 2'b11
   } hil_log_state_t;
endpackage : hil_pkg

// *** src/hil_log_writer.sv ***
// two-word log entry writer and count/pointer register
`timescale 1ns/1ps
module hil_log_writer
   import hil_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // entry request
   input wire logic entry_req,
   input wire logic [15:0] entry_id,
   output logic entry_busy,
   // count register access
   input wire logic count_read,
   output logic [15:0] count_log_q,
   // log memory port
   output hil_log_wr_t log_wr_q
);
   hil_log_state_t st_q, st_d;
   logic [6:0] cnt_q, cnt_d;
   logic [8:0] ptr_q, ptr_d;
   logic [15:0] id_q, id_d;
   hil_log_wr_t wr_d;

   assign entry_busy = (st_q != HIL_IDLE);
   assign count_log_q = {cnt_q, ptr_q};

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ptr_d = ptr_q;
      id_d = id_q;
      wr_d = '0;
      if (count_read) begin
         cnt_d = 7'h00;
      end
      unique case (st_q)
         HIL_IDLE: begin
            if (entry_req) begin
               id_d = entry_id;
               st_d = HIL_WR_ID;
            end
         end
         HIL_WR_ID: begin
            wr_d = '{we: 1'b1, addr: ptr_q, data: id_q};
            st_d = HIL_WR_ADDR;
         end
         HIL_WR_ADDR: begin
            wr_d = '{we: 1'b1, addr: ptr_q + 9'h001, data: HIL_LOG_ADDR_WORD};
            ptr_d = (ptr_q == HIL_LOG_LAST_PAIR) ? HIL_LOG_START : ptr_q + 9'h002;
            if (count_read) begin
               cnt_d = 7'h01;
            end else if (cnt_q != HIL_COUNT_MAX) begin
               cnt_d = cnt_q + 7'h01;
            end
            st_d = HIL_IDLE;
         end
         default: st_d = HIL_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= HIL_IDLE;
         cnt_q <= 7'h00;
         ptr_q <= HIL_LOG_START;
         id_q <= 16'h0000;
         log_wr_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ptr_q <= ptr_d;
         id_q <= id_d;
         log_wr_q <= wr_d;
      end
   end

   a_ptr_even: assert property (@(posedge sys_clk) disable iff (reset)
      !ptr_q[0] && ptr_q[8:6] == 3'b110) else $error("log pointer out of range");
   a_count_sat: assert property (@(posedge sys_clk) disable iff (reset)
      cnt_q == HIL_COUNT_MAX && !count_read |=> cnt_q == HIL_COUNT_MAX) else $error("count left saturation");
   a_read_clears: assert property (@(posedge sys_clk) disable iff (reset)
      count_read && st_q != HIL_WR_ADDR |=> cnt_q == 7'h00 && $stable(ptr_q)) else $error("count read wrong");
   sequence s_entry;
      st_q == HIL_WR_ID ##1 st_q == HIL_WR_ADDR;
   endsequence
   a_two_words: assert property (@(posedge sys_clk) disable iff (reset)
      s_entry |-> log_wr_q.we ##1 (log_wr_q.we && log_wr_q.data == 16'h0000)) else $error("log entry wrong");
   a_wrap: assert property (@(posedge sys_clk) disable iff (reset)
      st_q == HIL_WR_ADDR && ptr_q == HIL_LOG_LAST_PAIR |=> ptr_q == HIL_LOG_START) else $error("no wrap");
endmodule : hil_log_writer

// *** src/hil_irq_ctrl.sv ***
// hardware interrupt triplet, host request and log control
`timescale 1ns/1ps
module hil_irq_ctrl
   import hil_pkg::*;
(
   // clock and master reset
   input wire logic sys_clk,
   input wire logic reset,
   // host register access
   input hil_req_t host_req,
   output logic [15:0] host_rdata_q,
   // hardware event pulses, bits 15-3 used
   input wire logic [15:0] hw_event,
   // terminal interrupt sources
   input wire logic [15:0] term_event,
   input wire logic [15:0] term_event_enable,
   input wire logic [15:0] term_output_enable,
   input wire logic terminal_soft_reset_bit,
   // host interrupt request
   output logic irq_n,
   // log memory write port
   output hil_log_wr_t log_wr_q
);
   logic [15:0] hw_pend_q, hw_pend_d;
   logic [15:0] term_pend_q, term_pend_d;
   logic [15:0] hw_en_q, hw_en_d;
   logic [15:0] hw_oe_q, hw_oe_d;
   logic [15:0] rdata_d;
   logic [15:0] held_q, held_d;
   logic irq_q, irq_d;
   logic [15:0] hw_hit, term_hit, count_log;
   logic entry_busy, entry_req, count_read;
   logic [15:0] entry_id;

   function automatic logic is_read(input hil_req_t r, input logic [7:0] ofs);
      is_read = r.rd && (r.addr == ofs);
   endfunction : is_read

   function automatic logic is_write(input hil_req_t r, input logic [7:0] ofs);
      is_write = r.wr && (r.addr == ofs);
   endfunction : is_write

   assign hw_hit = hw_event & hw_en_q & HIL_HW_EVENT_MASK;
   assign term_hit = term_event & term_event_enable;
   assign count_read = is_read(host_req, HIL_OFS_COUNT_LOG);
   // events arriving while an entry is written are held and logged next
   assign entry_req = (held_q != 16'h0000);
   assign entry_id = held_q;

   always_comb begin
      hw_pend_d = hw_pend_q;
      term_pend_d = term_pend_q;
      hw_en_d = hw_en_q;
      hw_oe_d = hw_oe_q;
      held_d = held_q;
      rdata_d = host_rdata_q;
      if (is_read(host_req, HIL_OFS_HW_PEND)) begin
         hw_pend_d = 16'h0000;
      end
      if (is_read(host_req, HIL_OFS_TERM_PEND)) begin
         term_pend_d = 16'h0000;
      end
      hw_pend_d = hw_pend_d | hw_hit;
      term_pend_d = term_pend_d | term_hit;
      if (entry_req && !entry_busy) begin
         held_d = 16'h0000;
      end
      held_d = held_d | hw_hit;
      if (is_write(host_req, HIL_OFS_HW_EN)) begin
         hw_en_d = host_req.wdata;
      end
      if (is_write(host_req, HIL_OFS_HW_OE)) begin
         hw_oe_d = host_req.wdata;
      end
      if (host_req.rd) begin
         unique case (host_req.addr)
            HIL_OFS_HW_PEND: begin
               rdata_d = (hw_pend_q & HIL_HW_EVENT_MASK) |
                  ((term_pend_q != 16'h0000) ? 16'h0004 : 16'h0000);
            end
            HIL_OFS_TERM_PEND: rdata_d = term_pend_q;
            HIL_OFS_COUNT_LOG: rdata_d = count_log;
            HIL_OFS_HW_EN: rdata_d = hw_en_q;
            HIL_OFS_HW_OE: rdata_d = hw_oe_q;
            default: rdata_d = 16'h0000;
         endcase
      end
      // request stays while an output-enabled condition is pending
      irq_d = ((hw_pend_d & hw_oe_q) != 16'h0000) || ((term_pend_d & term_output_enable) != 16'h0000);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hw_pend_q <= 16'h0000;
         term_pend_q <= 16'h0000;
         hw_en_q <= HIL_HW_EN_RESET;
         hw_oe_q <= HIL_HW_OE_RESET;
         held_q <= 16'h0000;
         host_rdata_q <= 16'h0000;
         irq_q <= 1'b0;
      end else begin
         hw_pend_q <= hw_pend_d;
         term_pend_q <= term_pend_d;
         hw_en_q <= hw_en_d;
         hw_oe_q <= hw_oe_d;
         held_q <= held_d;
         host_rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign irq_n = ~irq_q;

   // soft reset is deliberately not connected to the count register
   hil_log_writer u_log (
      .sys_clk(sys_clk),
      .reset(reset),
      .entry_req(entry_req),
      .entry_id(entry_id),
      .entry_busy(entry_busy),
      .count_read(count_read),
      .count_log_q(count_log),
      .log_wr_q(log_wr_q)
   );

   a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      hw_pend_q == 16'h0000 && (hw_event & hw_en_q) == 16'h0000 && !host_req.wr
      |=> hw_pend_q == 16'h0000) else $error("pending set without enabled event");
   a_pend_set: assert property (@(posedge sys_clk) disable iff (reset)
      hw_hit[15] |=> hw_pend_q[15]) else $error("event lost");
   a_read_clear: assert property (@(posedge sys_clk) disable iff (reset)
      is_read(host_req, HIL_OFS_HW_PEND) && hw_hit == 16'h0000 |=> hw_pend_q == 16'h0000) else $error("no clear");
   a_term_clear: assert property (@(posedge sys_clk) disable iff (reset)
      is_read(host_req, HIL_OFS_TERM_PEND) && term_hit == 16'h0000 |=> term_pend_q == 16'h0000)
      else $error("terminal pending not cleared");
   a_irq_high: assert property (@(posedge sys_clk) disable iff (reset)
      (hw_hit & hw_oe_q) != 16'h0000 |=> !irq_n) else $error("request missing");
   a_irq_low: assert property (@(posedge sys_clk) disable iff (reset)
      ##1 (hw_pend_q & hw_oe_q) == 16'h0000 && (term_pend_q & term_output_enable) == 16'h0000
      && $stable(term_output_enable) |-> irq_n) else $error("low priority asserted request");
   a_summary: assert property (@(posedge sys_clk) disable iff (reset)
      is_read(host_req, HIL_OFS_HW_PEND) |=> host_rdata_q[HIL_SUMMARY_BIT] == ($past(term_pend_q) != 16'h0000))
      else $error("summary bit wrong");
   a_log_follow: assert property (@(posedge sys_clk) disable iff (reset)
      hw_hit != 16'h0000 |-> ##[1:8] log_wr_q.we) else $error("event not logged");
endmodule : hil_irq_ctrl

// *** sim/hil_host_model.sv ***
// host processor model driving register reads and writes
`timescale 1ns/1ps
module hil_host_model
   import hil_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register port
   output hil_req_t host_req,
   input wire logic [15:0] host_rdata_q
);
   initial begin
      host_req = '{rd: 1'b0, wr: 1'b0, addr: 8'hFF, wdata: 16'hFFFF};
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk);
      host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~host_req.wdata};
      @(negedge sys_clk);
      host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~host_req.wdata};
      d = host_rdata_q;
   endtask : rd
   // keeps hardware value, reads terminal pending when summary set
   task automatic service(output logic [15:0] hw, output logic [15:0] term);
      term = 16'h0000;
      rd(HIL_OFS_HW_PEND, hw);
      if (hw[HIL_SUMMARY_BIT] === 1'b1) begin
         rd(HIL_OFS_TERM_PEND, term);
      end
   endtask : service
endmodule : hil_host_model

// *** sim/hil_irq_ctrl_tb.sv ***
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module hil_irq_ctrl_tb;
   import hil_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   hil_req_t host_req;
   logic [15:0] host_rdata_q, hw_event = 16'h0000, term_event = 16'h0000;
   logic [15:0] term_en = 16'h0000, term_oe = 16'h0000, v, t;
   logic soft_rst = 1'b0, irq_n;
   hil_log_wr_t log_wr_q;
   logic [24:0] log_q[$];
   int mismatches = 0, num_checks = 0, cycles = 0;
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   hil_irq_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .host_req(host_req), .host_rdata_q(host_rdata_q),
      .hw_event(hw_event), .term_event(term_event), .term_event_enable(term_en),
      .term_output_enable(term_oe), .terminal_soft_reset_bit(soft_rst), .irq_n(irq_n), .log_wr_q(log_wr_q));
   hil_host_model u_host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata_q(host_rdata_q));
   always @(posedge sys_clk) begin
      if (log_wr_q.we === 1'b1) log_q.push_back({log_wr_q.addr, log_wr_q.data});
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic pulse(input logic [15:0] m, input int n);
      repeat (n) begin
         @(negedge sys_clk);
         hw_event = m;
         @(negedge sys_clk);
         hw_event = 16'h0000;
         repeat (8) @(negedge sys_clk);
      end
   endtask : pulse
   task automatic t_reset_values();
      u_host.rd(HIL_OFS_COUNT_LOG, v); `CHK(v, 16'h0180)
      u_host.rd(HIL_OFS_HW_EN, v); `CHK(v, HIL_HW_EN_RESET)
      u_host.rd(HIL_OFS_HW_OE, v); `CHK(v, 16'h0000)
      u_host.rd(8'h3C, v); `CHK(v, 16'h0000)
      `CHK(irq_n, 1'b1)
   endtask : t_reset_values
   task automatic t_high_priority();
      u_host.wr(HIL_OFS_HW_EN, 16'hF800);
      u_host.wr(HIL_OFS_HW_OE, 16'h8000);
      u_host.rd(HIL_OFS_HW_OE, v); `CHK(v, 16'h8000)
      log_q.delete();
      pulse(16'h8000, 1);
      `CHK(irq_n, 1'b0)
      `CHK(log_q.size(), 2)
      `CHK(log_q[0], {9'h180, 16'h8000})
      `CHK(log_q[1], {9'h181, HIL_LOG_ADDR_WORD})
      u_host.rd(HIL_OFS_HW_PEND, v); `CHK(v, 16'h8000)
      @(negedge sys_clk); `CHK(irq_n, 1'b1)
      u_host.rd(HIL_OFS_HW_PEND, v); `CHK(v, 16'h0000)
      u_host.rd(HIL_OFS_COUNT_LOG, v); `CHK(v, 16'h0382)
      u_host.wr(HIL_OFS_COUNT_LOG, 16'hFFFF);
      u_host.rd(HIL_OFS_COUNT_LOG, v); `CHK(v, 16'h0182)
   endtask : t_high_priority
   task automatic t_disabled();
      log_q.delete();
      pulse(16'h0008, 1);
      `CHK(irq_n, 1'b1)
      `CHK(log_q.size(), 0)
      u_host.wr(HIL_OFS_HW_EN, 16'hF808);
      repeat (4) @(negedge sys_clk);
      u_host.rd(HIL_OFS_HW_PEND, v); `CHK(v, 16'h0000)
      `CHK(log_q.size(), 0)
   endtask : t_disabled
   task automatic t_low_priority();
      pulse(16'h4000, 1);
      `CHK(irq_n, 1'b1)
      u_host.rd(HIL_OFS_HW_PEND, v); `CHK(v, 16'h4000)
   endtask : t_low_priority
   task automatic t_wrap_saturate();
      log_q.delete();
      pulse(16'h4000, 30);
      `CHK(log_q[59], {9'h1BF, HIL_LOG_ADDR_WORD})
      u_host.rd(HIL_OFS_COUNT_LOG, v); `CHK(v, 16'h3F80)
      pulse(16'h4000, 130);
      soft_rst = 1'b1;
      repeat (3) @(negedge sys_clk);
      soft_rst = 1'b0;
      u_host.rd(HIL_OFS_COUNT_LOG, v); `CHK(v, 16'hFF84)
      u_host.rd(HIL_OFS_HW_PEND, v);
   endtask : t_wrap_saturate
   task automatic t_terminal();
      term_en = 16'h0001;
      term_oe = 16'h0001;
      @(negedge sys_clk);
      term_event = 16'h0001;
      @(negedge sys_clk);
      term_event = 16'h0000;
      repeat (8) @(negedge sys_clk);
      `CHK(irq_n, 1'b0)
      u_host.service(v, t);
      `CHK(v, 16'h0004)
      `CHK(t, 16'h0001)
      u_host.rd(HIL_OFS_TERM_PEND, v); `CHK(v, 16'h0000)
      `CHK(irq_n, 1'b1)
   endtask : t_terminal
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      t_reset_values();
      t_high_priority();
      t_disabled();
      t_low_priority();
      t_wrap_saturate();
      t_terminal();
      stop_test();
   end
endmodule : hil_irq_ctrl_tb
